// *** hdl/pls_buffer.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module pls_buffer #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic [1:0] cnt;
    logic vld;
  } pls_buf_t;

  pls_buf_t s;
  pls_buf_t next_s;

  assign in_ready = (s.cnt != 2'h2);
  assign out_valid = s.vld;
  assign out_data = s.d0;

  always_comb begin
    next_s = s;
    if (out_valid && out_ready) begin
      next_s.d0 = s.d1;
      next_s.cnt = next_s.cnt - 2'h1;
    end
    if (in_valid && in_ready) begin
      if (next_s.cnt == 2'h0) begin
        next_s.d0 = in_data;
      end else begin
        next_s.d1 = in_data;
      end
      next_s.cnt = next_s.cnt + 2'h1;
    end
    next_s.vld = (next_s.cnt != 2'h0);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : pls_buffer

// *** hdl/pls_loader.sv ***
// Program memory loader control: registers, pointer, memories and check timer
`timescale 1ns/1ps
module pls_loader #(
  parameter int unsigned CHECK_CYCLES = pls_pkg::CHECK_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [pls_pkg::REG_AW-1:0] reg_addr,
  input wire logic [pls_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic reg_req_ready,
  output logic [pls_pkg::REG_DW-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  input wire logic i2c_stop,
  output logic cpu_reset,
  output logic cpu_fetch_ram,
  output logic cpu_parity_enable,
  input wire logic cpu_fetch_req,
  input wire logic [pls_pkg::MEM_AW-1:0] cpu_fetch_addr,
  output logic [pls_pkg::MEM_DW-1:0] cpu_fetch_data,
  output logic cpu_fetch_valid,
  output logic cpu_parity_error,
  input wire logic cpu_check_done,
  input wire logic cpu_check_valid,
  input wire logic [pls_pkg::REG_DW-1:0] cpu_version,
  output logic safe_mode
);
  import pls_pkg::*;

  typedef struct packed {
    logic [REG_DW-1:0] ctrl;
    logic [REG_DW-1:0] sa_lo;
    logic [REG_DW-1:0] sa_hi;
    logic [REG_DW-1:0] version;
    logic [PTR_W-1:0] ptr;
    logic armed;
    logic pend;
    logic pend_mem;
    logic pend_par;
    logic [REG_DW-1:0] hold;
    logic req_ready;
    logic [TIMER_W-1:0] timer;
    pls_chk_t chk;
    logic safe;
    logic fetch_pend;
    logic fetch_valid;
    logic [MEM_DW-1:0] fetch_data;
    logic parity_error;
  } pls_state_t;

  localparam logic [TIMER_W-1:0] CHECK_LAST = TIMER_W'(CHECK_CYCLES - 1);

  function automatic logic is_reg(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] r);
    is_reg = (a == r);
  endfunction : is_reg

  // Data port hit: right address, port open and the access in the selected direction
  function automatic logic port_hit(input logic [REG_AW-1:0] a, input logic open,
      input logic dir, input logic want_read);
    port_hit = is_reg(a, ADDR_DATA) & open & (dir == want_read);
  endfunction : port_hit

  pls_state_t s;
  pls_state_t next_s;

  logic host_ok;
  logic fetch_ok;
  logic port_open;
  logic wr_data_ok;
  logic rd_take;
  logic rd_data_ok;
  logic ram_rise;
  logic [MEM_AW-1:0] mem_addr;
  logic prog_we;
  logic par_we;
  logic mem_re;
  logic [MEM_DW-1:0] prog_q;
  logic [MEM_DW-1:0] par_q;
  logic buf_in_ready;
  logic [REG_DW-1:0] push_data;
  logic [REG_DW-1:0] reg_value;

  pls_mem #(.AW(MEM_AW), .DW(MEM_DW)) u_prog (
    .mclk(mclk),
    .rst(rst),
    .addr(mem_addr),
    .we(prog_we),
    .re(mem_re),
    .wdata(reg_wdata),
    .q(prog_q)
  );

  pls_mem #(.AW(MEM_AW), .DW(MEM_DW)) u_par (
    .mclk(mclk),
    .rst(rst),
    .addr(mem_addr),
    .we(par_we),
    .re(mem_re),
    .wdata(reg_wdata),
    .q(par_q)
  );

  pls_buffer #(.W(REG_DW)) u_buf (
    .mclk(mclk),
    .rst(rst),
    .in_valid(s.pend),
    .in_ready(buf_in_ready),
    .in_data(push_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign reg_req_ready = s.req_ready;
  assign cpu_reset = s.ctrl[B_HOLD];
  assign cpu_fetch_ram = s.ctrl[B_RAM];
  assign cpu_parity_enable = s.ctrl[B_PCHK];
  assign cpu_fetch_data = s.fetch_data;
  assign cpu_fetch_valid = s.fetch_valid;
  assign cpu_parity_error = s.parity_error;
  assign safe_mode = s.safe;

  always_comb begin
    next_s = s;
    reg_value = READ_ZERO;

    // Data port usable only with host access and CPU held
    host_ok = s.ctrl[B_HOST] & s.ctrl[B_HOLD];
    port_open = host_ok & s.armed & ~s.ctrl[B_CLR];
    fetch_ok = s.ctrl[B_RAM] & ~s.ctrl[B_HOLD];
    wr_data_ok = reg_wr & port_hit(reg_addr, port_open, s.ctrl[B_DIR], 1'b0);
    rd_take = reg_rd & s.req_ready;
    rd_data_ok = rd_take & port_hit(reg_addr, port_open, s.ctrl[B_DIR], 1'b1);

    // Memory port shared between host bursts and CPU fetch
    mem_addr = host_ok ? s.ptr[MEM_AW-1:0] : cpu_fetch_addr;
    prog_we = wr_data_ok & ~s.ctrl[B_PSEL];
    par_we = wr_data_ok & s.ctrl[B_PSEL];
    mem_re = rd_data_ok | (cpu_fetch_req & fetch_ok);

    // Register writes; rst clears these, a failed check clears ctrl B_RAM, never the CPU hold
    if (reg_wr) begin
      if (is_reg(reg_addr, ADDR_CTRL)) begin
        next_s.ctrl = reg_wdata;
      end
      if (is_reg(reg_addr, ADDR_SA_LO)) begin
        next_s.sa_lo = reg_wdata;
      end
      if (is_reg(reg_addr, ADDR_SA_HI)) begin
        next_s.sa_hi = reg_wdata;
      end
    end

    // Address pointer
    if (i2c_stop) begin
      next_s.armed = 1'b0;
    end
    if (s.ctrl[B_CLR]) begin
      next_s.ptr = '0;
      next_s.armed = 1'b0;
      if (!next_s.ctrl[B_CLR]) begin
        next_s.ptr = {s.sa_hi, s.sa_lo};
        next_s.armed = 1'b1;
      end
    end else if (wr_data_ok || rd_data_ok) begin
      next_s.ptr = s.ptr + 16'h0001;
    end

    // Register read value
    unique case (1'b1)
      is_reg(reg_addr, ADDR_CTRL): reg_value = s.ctrl;
      is_reg(reg_addr, ADDR_SA_LO): reg_value = s.sa_lo;
      is_reg(reg_addr, ADDR_SA_HI): reg_value = s.sa_hi;
      is_reg(reg_addr, ADDR_VERSION): reg_value = s.version;
      default: reg_value = READ_ZERO;
    endcase

    // Read requests go through the buffer
    if (rd_take) begin
      next_s.pend = 1'b1;
      next_s.pend_mem = rd_data_ok;
      next_s.pend_par = s.ctrl[B_PSEL];
      next_s.hold = is_reg(reg_addr, ADDR_DATA) ? READ_ZERO : reg_value;
    end else if (s.pend && buf_in_ready) begin
      next_s.pend = 1'b0;
    end
    next_s.req_ready = ~next_s.pend;
    if (s.pend_mem) begin
      push_data = s.pend_par ? par_q : prog_q;
    end else begin
      push_data = s.hold;
    end

    // Compatibility check after execution is enabled
    ram_rise = ~s.ctrl[B_RAM] & next_s.ctrl[B_RAM];
    unique case (s.chk)
      CHK_IDLE, CHK_SAFE: begin
        if (ram_rise) begin
          next_s.timer = '0;
          next_s.chk = CHK_RUN;
        end
      end
      CHK_RUN: begin
        next_s.timer = s.timer + 16'h0001;
        if (ram_rise) begin
          // A fresh enable restarts the check window
          next_s.timer = '0;
        end else if (cpu_check_done && cpu_check_valid) begin
          next_s.version = cpu_version;
          next_s.safe = 1'b0;
          next_s.chk = CHK_IDLE;
        end else if (cpu_check_done || s.timer == CHECK_LAST) begin
          next_s.version = VERSION_INVALID;
          next_s.ctrl[B_RAM] = 1'b0;
          next_s.safe = 1'b1;
          next_s.chk = CHK_SAFE;
        end
      end
      default: next_s.chk = CHK_IDLE;
    endcase

    // CPU fetch with parity check
    next_s.fetch_pend = cpu_fetch_req & fetch_ok;
    next_s.fetch_valid = s.fetch_pend;
    if (s.fetch_pend) begin
      next_s.fetch_data = prog_q;
    end
    next_s.parity_error = s.fetch_pend & s.ctrl[B_PCHK] & ((^prog_q) != par_q[0]);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.sa_lo <= SA_RESET;
      s.sa_hi <= SA_RESET;
      s.version <= VERSION_RESET;
      s.chk <= CHK_IDLE;
    end else begin
      s <= next_s;
    end
  end
endmodule : pls_loader

// *** hdl/pls_mem.sv ***
// Single-port memory with registered read data
`timescale 1ns/1ps
module pls_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic re,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] q
);
  logic [DW-1:0] store [2**AW];

  always_ff @(posedge mclk) begin
    if (we) begin
      store[addr] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else if (re) begin
      q <= store[addr];
    end
  end
endmodule : pls_mem

// *** pkg/pls_pkg.sv ***
// Constants shared by the program memory loader control block
package pls_pkg;
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  localparam int MEM_AW = 12;
  localparam int MEM_DW = 8;
  localparam int PTR_W = 16;
  localparam int TIMER_W = 16;

  localparam logic [REG_AW-1:0] ADDR_VERSION = 8'h41;
  localparam logic [REG_AW-1:0] ADDR_CTRL = 8'h60;
  localparam logic [REG_AW-1:0] ADDR_DATA = 8'h61;
  localparam logic [REG_AW-1:0] ADDR_SA_LO = 8'h62;
  localparam logic [REG_AW-1:0] ADDR_SA_HI = 8'h63;

  localparam int B_HOST = 7;
  localparam int B_HOLD = 6;
  localparam int B_PCHK = 4;
  localparam int B_RAM = 3;
  localparam int B_PSEL = 2;
  localparam int B_DIR = 1;
  localparam int B_CLR = 0;

  localparam logic [REG_DW-1:0] CTRL_RESET = 8'h00;
  localparam logic [REG_DW-1:0] SA_RESET = 8'h00;
  localparam logic [REG_DW-1:0] VERSION_RESET = 8'h00;
  localparam logic [REG_DW-1:0] VERSION_INVALID = 8'hff;
  localparam logic [REG_DW-1:0] READ_ZERO = 8'h00;

  localparam int CLK_KHZ = 10000;
  localparam int CHECK_TIME_MS = 1;
  localparam int CHECK_CYCLES_DEF = CHECK_TIME_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    CHK_IDLE = 2'b00,
    CHK_RUN = 2'b01,
    CHK_SAFE = 2'b11
  } pls_chk_t;
endpackage : pls_pkg

// *** verif/pls_chk.sv ***
// Port assertions for the program memory loader
`timescale 1ns/1ps
module pls_chk #(
  parameter int unsigned CHECK_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [pls_pkg::REG_AW-1:0] reg_addr,
  input wire logic [pls_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_req_ready,
  input wire logic [pls_pkg::REG_DW-1:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic cpu_reset,
  input wire logic cpu_fetch_ram,
  input wire logic cpu_parity_enable,
  input wire logic cpu_fetch_req,
  input wire logic cpu_fetch_valid,
  input wire logic cpu_parity_error,
  input wire logic cpu_check_done,
  input wire logic cpu_check_valid,
  input wire logic safe_mode
);
  import pls_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic ctl_wr = reg_wr && reg_addr == ADDR_CTRL;
  property p_rst;
    disable iff (1'b0) rst |=> !cpu_reset && !cpu_fetch_ram && !rd_valid && !safe_mode;
  endproperty
  property p_hold;
    ctl_wr |=> cpu_reset == $past(reg_wdata[B_HOLD]);
  endproperty
  property p_pchk;
    ctl_wr |=> cpu_parity_enable == $past(reg_wdata[B_PCHK]);
  endproperty
  property p_ram;
    $rose(cpu_fetch_ram) |-> $past(ctl_wr && reg_wdata[B_RAM]);
  endproperty
  property p_fetch;
    cpu_fetch_req && cpu_fetch_ram && !cpu_reset |-> ##2 cpu_fetch_valid;
  endproperty
  property p_fvalid;
    cpu_fetch_valid |-> $past(cpu_fetch_req, 2);
  endproperty
  property p_perr;
    cpu_parity_error |-> cpu_fetch_valid && cpu_parity_enable;
  endproperty
  property p_rd;
    reg_rd && reg_req_ready && !rd_valid |-> ##2 rd_valid;
  endproperty
  property p_stall;
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
  endproperty
  property p_safe;
    cpu_fetch_ram && cpu_check_done && !cpu_check_valid |-> ##[1:2] (safe_mode && !cpu_fetch_ram);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_hold: assert property (p_hold) else $error("cpu reset not bit 6");
  a_pchk: assert property (p_pchk) else $error("parity enable not bit 4");
  a_ram: assert property (p_ram) else $error("execute enable rose unasked");
  a_fetch: assert property (p_fetch) else $error("fetch not answered");
  a_fvalid: assert property (p_fvalid) else $error("fetch answer without request");
  a_perr: assert property (p_perr) else $error("stray parity error");
  a_rd: assert property (p_rd) else $error("read answer late");
  a_stall: assert property (p_stall) else $error("read data lost on stall");
  a_safe: assert property (p_safe) else $error("invalid check not handled");
  c_perr: cover property (cpu_fetch_valid && cpu_parity_error);
  c_safe: cover property ($rose(safe_mode));
  c_full: cover property (rd_valid && !rd_ready && !reg_req_ready);
endmodule : pls_chk

bind pls_loader pls_chk #(.CHECK_CYCLES(CHECK_CYCLES)) pls_chk_i (.mclk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_req_ready, .rd_data, .rd_valid, .rd_ready, .cpu_reset,
  .cpu_fetch_ram, .cpu_parity_enable, .cpu_fetch_req, .cpu_fetch_valid, .cpu_parity_error,
  .cpu_check_done, .cpu_check_valid, .safe_mode);

// *** verif/pls_host.sv ***
// Host register master model for the loader's command port
`timescale 1ns/1ps
module pls_host (
  input wire logic mclk,
  input wire logic reg_req_ready,
  input wire logic [pls_pkg::REG_DW-1:0] rd_data,
  input wire logic rd_valid,
  output logic [pls_pkg::REG_AW-1:0] reg_addr,
  output logic [pls_pkg::REG_DW-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic rd_ready,
  output logic i2c_stop,
  output logic hung
);
  import pls_pkg::*;
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, rd_ready, i2c_stop, hung} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic iss(input logic [7:0] a);
    @(negedge mclk);
    for (int n = 0; n < 50 && reg_req_ready !== 1'b1; n++) @(negedge mclk);
    hung |= reg_req_ready !== 1'b1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : iss
  task automatic pop(output logic [7:0] d);
    @(negedge mclk);
    for (int n = 0; n < 50 && rd_valid !== 1'b1; n++) @(negedge mclk);
    hung |= rd_valid !== 1'b1;
    d = rd_data;
    rd_ready = 1'b1;
    @(negedge mclk);
    rd_ready = 1'b0;
  endtask : pop
  task automatic arm(input logic [7:0] c);
    wr(ADDR_CTRL, c | 8'h01);
    wr(ADDR_CTRL, c);
  endtask : arm
  task automatic stop;
    @(negedge mclk);
    i2c_stop = 1'b1;
    @(negedge mclk);
    i2c_stop = 1'b0;
  endtask : stop
endmodule : pls_host

// *** verif/pls_loader_tb.sv ***
// Self-checking bench for the program memory loader control
`timescale 1ns/1ps
module pls_loader_tb;
  import pls_pkg::*;
  localparam int unsigned CYC = 30;
  logic mclk, rst, reg_wr, reg_rd, reg_req_ready, rd_valid, rd_ready, i2c_stop, hung;
  logic cpu_reset, cpu_fetch_ram, cpu_parity_enable, cpu_fetch_req, cpu_fetch_valid;
  logic cpu_parity_error, cpu_check_done, cpu_check_valid, safe_mode;
  logic [7:0] reg_addr, reg_wdata, rd_data, cpu_version, cpu_fetch_data, v;
  logic [11:0] cpu_fetch_addr;
  logic [7:0] pm [4] = '{8'h11, 8'h22, 8'h34, 8'h5a};
  logic [7:0] tbl [5] = '{ADDR_CTRL, ADDR_SA_LO, ADDR_SA_HI, ADDR_VERSION, 8'h50};
  int num_errors = 0;
  int samples_checked = 0;
  pls_loader #(.CHECK_CYCLES(CYC)) pls_loader_i (.mclk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_req_ready, .rd_data, .rd_valid, .rd_ready, .i2c_stop, .cpu_reset,
    .cpu_fetch_ram, .cpu_parity_enable, .cpu_fetch_req, .cpu_fetch_addr, .cpu_fetch_data,
    .cpu_fetch_valid, .cpu_parity_error, .cpu_check_done, .cpu_check_valid, .cpu_version,
    .safe_mode);
  pls_host pls_host_i (.mclk, .reg_req_ready, .rd_data, .rd_valid, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .rd_ready, .i2c_stop, .hung);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    pls_host_i.iss(a);
    pls_host_i.pop(d);
  endtask : rd
  task automatic fetch(input logic [11:0] a, input logic [7:0] d, input logic e, input logic q);
    @(negedge mclk);
    cpu_fetch_addr = a;
    cpu_fetch_req = q;
    @(negedge mclk);
    cpu_fetch_req = 1'b0;
    @(negedge mclk);
    chk(cpu_fetch_valid, q);
    chk(cpu_fetch_data, d);
    chk(cpu_parity_error, e);
  endtask : fetch
  task automatic verdict(input logic done, input logic ok, input logic [7:0] ver);
    @(negedge mclk);
    cpu_version = ver;
    cpu_check_valid = ok;
    cpu_check_done = done;
    @(negedge mclk);
    cpu_check_done = 1'b0;
  endtask : verdict
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #(20000 * 100);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    cpu_fetch_req = 1'b0;
    cpu_fetch_addr = 12'h000;
    cpu_check_done = 1'b0;
    cpu_check_valid = 1'b0;
    cpu_version = 8'h00;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    foreach (tbl[i]) begin
      rd(tbl[i], v);
      chk(v, 8'h00);
    end
    pls_host_i.wr(ADDR_SA_LO, 8'h23);
    pls_host_i.wr(ADDR_SA_HI, 8'hf1);
    pls_host_i.wr(ADDR_CTRL, 8'he0);
    chk(cpu_reset, 1'b1);
    pls_host_i.wr(ADDR_CTRL, 8'ha0);
    chk(cpu_reset, 1'b0);
    pls_host_i.wr(ADDR_CTRL, 8'he0);
    rd(ADDR_SA_LO, v);
    chk(v, 8'h23);
    rd(ADDR_SA_HI, v);
    chk(v, 8'hf1);
    rd(ADDR_CTRL, v);
    chk(v, 8'he0);
    pls_host_i.arm(8'hc0);
    foreach (pm[i]) pls_host_i.wr(ADDR_DATA, pm[i]);
    pls_host_i.stop();
    pls_host_i.arm(8'hc4);
    foreach (pm[i]) pls_host_i.wr(ADDR_DATA, {7'h00, (^pm[i]) ^ (i == 3)});
    pls_host_i.stop();
    pls_host_i.arm(8'h40);
    pls_host_i.wr(ADDR_DATA, 8'hee);
    pls_host_i.arm(8'h42);
    rd(ADDR_DATA, v);
    chk(v, READ_ZERO);
    pls_host_i.arm(8'hc2);
    foreach (pm[i]) begin
      rd(ADDR_DATA, v);
      chk(v, pm[i]);
    end
    pls_host_i.stop();
    rd(ADDR_DATA, v);
    chk(v, READ_ZERO);
    pls_host_i.arm(8'hc6);
    foreach (pm[i]) begin
      rd(ADDR_DATA, v);
      chk(v, {7'h00, (^pm[i]) ^ (i == 3)});
    end
    pls_host_i.wr(ADDR_SA_LO, 8'h25);
    pls_host_i.arm(8'hc2);
    rd(ADDR_DATA, v);
    chk(v, pm[2]);
    pls_host_i.wr(ADDR_SA_LO, 8'h23);
    pls_host_i.arm(8'hc2);
    repeat (3) pls_host_i.iss(ADDR_DATA);
    repeat (4) @(negedge mclk);
    chk(reg_req_ready, 1'b0);
    for (int i = 0; i < 3; i++) begin
      pls_host_i.pop(v);
      chk(v, pm[i]);
    end
    pls_host_i.stop();
    pls_host_i.wr(ADDR_CTRL, 8'h18);
    chk(cpu_fetch_ram, 1'b1);
    chk(cpu_parity_enable, 1'b1);
    foreach (pm[i]) fetch(12'h123 + 12'(i), pm[i], i == 3, 1'b1);
    fetch(12'h124, pm[3], 1'b0, 1'b0);
    verdict(1'b1, 1'b1, 8'h07);
    rd(ADDR_VERSION, v);
    chk(v, 8'h07);
    chk(safe_mode, 1'b0);
    pls_host_i.wr(ADDR_CTRL, 8'h10);
    pls_host_i.wr(ADDR_CTRL, 8'h18);
    verdict(1'b0, 1'b1, 8'h33);
    repeat (CYC + 3) @(negedge mclk);
    chk(safe_mode, 1'b1);
    rd(ADDR_VERSION, v);
    chk(v, VERSION_INVALID);
    rd(ADDR_CTRL, v);
    chk(v, 8'h10);
    pls_host_i.wr(ADDR_CTRL, 8'h18);
    verdict(1'b1, 1'b0, 8'h07);
    @(negedge mclk);
    chk(cpu_fetch_ram, 1'b0);
    chk(hung, 1'b0);
    tally_and_finish();
  end
endmodule : pls_loader_tb
